// *** logic/operation_complete_tracker.sv ***
`timescale 1ns/1ps
module operation_complete_tracker #(
   parameter int OP_COUNT = status_report_pkg::OP_COUNT_DEFAULT
) (
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                arm,
   input  wire logic                cancel,
   input  wire logic [OP_COUNT-1:0] pending,
   output logic                     done
);
   import status_report_pkg::*;

   typedef struct packed {
      track_state_e        state;
      logic [OP_COUNT-1:0] snapshot;
      logic                done;
   } tracker_s;

   tracker_s cur;
   tracker_s next_cur;

   // only operations pending at the arm are waited for; later ones are ignored
   always_comb begin
      next_cur      = cur;
      next_cur.done = 1'b0;
      unique case (cur.state)
         TRACK_IDLE: begin
            if (arm && !cancel) begin
               next_cur.snapshot = pending;
               next_cur.state    = TRACK_WAIT;
            end
         end
         TRACK_WAIT: begin
            next_cur.snapshot = cur.snapshot & pending;
            if (cancel) begin
               next_cur.state = TRACK_IDLE;
            end else if ((cur.snapshot & pending) == '0) begin
               next_cur.done  = 1'b1;
               next_cur.state = TRACK_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cur.state    <= TRACK_IDLE;
         cur.snapshot <= '0;
         cur.done     <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   assign done = cur.done;

endmodule

// *** logic/status_report_pkg.sv ***
// Behaviour
// - bit 0 is OR of enabled measure events
// - bit 1 is OR of enabled source events
// - bit 2 high while error queue non-empty
// - bit 4 high while output queue non-empty
// - bit 5 is OR of enabled standard events
// - master summary ORs enabled bits except 6
// - latch sets on summary rise, clears on serial poll or while summary low
// - service request follows the latch, not status bit 6
// - byte query returns summary, changes nothing
// - serial poll returns latch, clears only it
// - disabled bits never reach master summary
// - clear-status clears events, flushes output queue when CMD_AFTER_TERM set
// - power-on sets standard event bit 7
// - syntax error sets standard event bit 5
// - execution error sets standard event bit 4
// - internal error sets standard event bit 3
// - query error sets standard event bit 2
// - completed pending operations set bit 0
// - standard event bits 6, 1 read zero
// - disabled standard bits never reach summary
// - event register read returns then clears
// - event register cleared only three ways
package status_report_pkg;

   // host command codes on the command port
   localparam logic [3:0] CMD_STB_QUERY   = 4'h1;
   localparam logic [3:0] CMD_SERIAL_POLL = 4'h2;
   localparam logic [3:0] CMD_SRE_WRITE   = 4'h3;
   localparam logic [3:0] CMD_SRE_READ    = 4'h4;
   localparam logic [3:0] CMD_ESE_WRITE   = 4'h5;
   localparam logic [3:0] CMD_ESE_READ    = 4'h6;
   localparam logic [3:0] CMD_ESR_READ    = 4'h7;
   localparam logic [3:0] CMD_CLS         = 4'h8;
   localparam logic [3:0] CMD_OP_COMPLETE = 4'h9;

   // status summary byte field positions
   localparam int STB_MEASURE_SUMMARY = 0;
   localparam int STB_SOURCE_SUMMARY  = 1;
   localparam int STB_ERROR_AVAILABLE = 2;
   localparam int STB_MESSAGE_AVAIL   = 4;
   localparam int STB_STANDARD_EVENT  = 5;
   localparam int STB_MASTER_BIT      = 6;

   // standard event flag positions
   localparam int SEF_OPERATION_COMPLETE = 0;
   localparam int SEF_QUERY_ERROR        = 2;
   localparam int SEF_INTERNAL_ERROR     = 3;
   localparam int SEF_EXECUTION_ERROR    = 4;
   localparam int SEF_SYNTAX_ERROR       = 5;
   localparam int SEF_POWER_ON           = 7;

   // bits that can ever be one
   localparam logic [7:0] SEF_IMPLEMENTED = 8'hbd;
   localparam logic [7:0] SRE_WRITABLE    = 8'hbf;

   // reset values
   localparam logic [7:0] SEF_RESET = 8'h80;
   localparam logic [7:0] SRE_RESET = 8'h00;
   localparam logic [7:0] ESE_RESET = 8'h00;

   // defaults for module parameters
   localparam int EVENT_WIDTH_DEFAULT = 16;
   localparam int OP_COUNT_DEFAULT    = 4;

   // operation-complete tracker states
   typedef enum logic [1:0] {
      TRACK_IDLE = 2'b01,
      TRACK_WAIT = 2'b10
   } track_state_e;

endpackage

// *** logic/status_report_service_request.sv ***
`timescale 1ns/1ps
module status_report_service_request #(
   parameter int EVENT_WIDTH = status_report_pkg::EVENT_WIDTH_DEFAULT,
   parameter int OP_COUNT    = status_report_pkg::OP_COUNT_DEFAULT
) (
   input  wire logic                   CLOCK,
   input  wire logic                   RSTN,
   input  wire logic                   CMD_VALID,
   input  wire logic [3:0]             CMD_CODE,
   input  wire logic [7:0]             CMD_DATA,
   input  wire logic                   CMD_AFTER_TERM,
   input  wire logic                   SYNTAX_ERROR,
   input  wire logic                   EXECUTION_ERROR,
   input  wire logic                   INTERNAL_ERROR,
   input  wire logic                   QUERY_ERROR,
   input  wire logic [OP_COUNT-1:0]    OPS_PENDING,
   input  wire logic [EVENT_WIDTH-1:0] SOURCE_EVENT,
   input  wire logic [EVENT_WIDTH-1:0] SOURCE_ENABLE,
   input  wire logic [EVENT_WIDTH-1:0] MEASURE_EVENT,
   input  wire logic [EVENT_WIDTH-1:0] MEASURE_ENABLE,
   input  wire logic                   ERROR_QUEUE_NOT_EMPTY,
   input  wire logic                   OUTPUT_QUEUE_NOT_EMPTY,
   output logic                        RESP_VALID,
   output logic [7:0]                  RESP_DATA,
   output logic                        SERVICE_REQUEST,
   output logic [7:0]                  STATUS_BYTE,
   output logic                        CLEAR_EVENTS,
   output logic                        FLUSH_OUTPUT_QUEUE
);
   import status_report_pkg::*;

   typedef struct packed {
      logic [7:0] service_enable;
      logic [7:0] standard_enable;
      logic [7:0] standard_event_flags;
      logic       summary_prev;
      logic       request_service_latch;
      logic [7:0] status_summary_byte;
      logic [7:0] resp_data;
      logic       resp_valid;
      logic       clear_events;
      logic       flush_queue;
   } status_s;

   status_s cur;
   status_s next_cur;

   // masked reduction for the measure and source summary bits
   function automatic logic masked_any(input logic [EVENT_WIDTH-1:0] ev,
                                       input logic [EVENT_WIDTH-1:0] en);
      masked_any = |(ev & en);
   endfunction

   function automatic logic masked_any8(input logic [7:0] ev, input logic [7:0] en);
      masked_any8 = |(ev & en);
   endfunction

   logic       ops_done;
   logic       cmd_op_complete;
   logic       cmd_cls;
   logic       cmd_poll;
   logic       cmd_esr_read;
   logic [7:0] event_sets;
   logic [7:0] stb_low;
   logic       master_summary;
   logic [7:0] stb_query_value;
   logic [7:0] stb_poll_value;

   // command decode; unknown codes are dropped without an answer
   always_comb begin
      cmd_op_complete = CMD_VALID && (CMD_CODE == CMD_OP_COMPLETE);
      cmd_cls         = CMD_VALID && (CMD_CODE == CMD_CLS);
      cmd_poll        = CMD_VALID && (CMD_CODE == CMD_SERIAL_POLL);
      cmd_esr_read    = CMD_VALID && (CMD_CODE == CMD_ESR_READ);
   end

   // a clear-status also abandons a waiting operation-complete
   operation_complete_tracker #(
      .OP_COUNT (OP_COUNT)
   ) u_tracker (
      .clk     (CLOCK),
      .rstn    (RSTN),
      .arm     (cmd_op_complete),
      .cancel  (cmd_cls),
      .pending (OPS_PENDING),
      .done    (ops_done)
   );

   // event pulses landing in the standard event flags
   always_comb begin
      event_sets                         = 8'h00;
      event_sets[SEF_SYNTAX_ERROR]       = SYNTAX_ERROR;
      event_sets[SEF_EXECUTION_ERROR]    = EXECUTION_ERROR;
      event_sets[SEF_INTERNAL_ERROR]     = INTERNAL_ERROR;
      event_sets[SEF_QUERY_ERROR]        = QUERY_ERROR;
      event_sets[SEF_OPERATION_COMPLETE] = ops_done;
   end

   // status byte without bit 6; bits 3 and 7 stay zero
   always_comb begin
      stb_low = 8'h00;
      stb_low[STB_MEASURE_SUMMARY] = masked_any(MEASURE_EVENT, MEASURE_ENABLE);
      stb_low[STB_SOURCE_SUMMARY]  = masked_any(SOURCE_EVENT, SOURCE_ENABLE);
      stb_low[STB_ERROR_AVAILABLE] = ERROR_QUEUE_NOT_EMPTY;
      stb_low[STB_MESSAGE_AVAIL]   = OUTPUT_QUEUE_NOT_EMPTY;
      // disabled standard bits drop out here
      stb_low[STB_STANDARD_EVENT]  =
         masked_any8(cur.standard_event_flags, cur.standard_enable);
   end

   // bit 6 of the enable never stored, so it cannot feed back into itself
   always_comb begin
      master_summary = masked_any8(stb_low, cur.service_enable);
      stb_query_value = stb_low;
      stb_query_value[STB_MASTER_BIT] = master_summary;
      stb_poll_value = stb_low;
      stb_poll_value[STB_MASTER_BIT] = cur.request_service_latch;
   end

   // one update of all state per clock
   always_comb begin
      next_cur              = cur;
      next_cur.resp_valid   = 1'b0;
      next_cur.clear_events = 1'b0;
      next_cur.flush_queue  = 1'b0;
      next_cur.summary_prev = master_summary;

      // standard flags: sticky, cleared only by read or clear-status
      if (cmd_esr_read || cmd_cls) begin
         next_cur.standard_event_flags = 8'h00;
      end
      // a set in the same cycle as the clear survives it
      next_cur.standard_event_flags =
         (next_cur.standard_event_flags | event_sets) & SEF_IMPLEMENTED;

      // latch clears first so a fresh rise in the same cycle still wins
      if (cmd_poll || !master_summary) begin
         next_cur.request_service_latch = 1'b0;
      end
      if (master_summary && !cur.summary_prev) begin
         next_cur.request_service_latch = 1'b1;
      end

      if (CMD_VALID) begin
         unique case (CMD_CODE)
            CMD_STB_QUERY: begin
               next_cur.resp_data  = stb_query_value;
               next_cur.resp_valid = 1'b1;
            end
            CMD_SERIAL_POLL: begin
               next_cur.resp_data  = stb_poll_value;
               next_cur.resp_valid = 1'b1;
            end
            CMD_SRE_WRITE: begin
               next_cur.service_enable = CMD_DATA & SRE_WRITABLE;
            end
            CMD_SRE_READ: begin
               next_cur.resp_data  = cur.service_enable;
               next_cur.resp_valid = 1'b1;
            end
            CMD_ESE_WRITE: begin
               next_cur.standard_enable = CMD_DATA;
            end
            CMD_ESE_READ: begin
               next_cur.resp_data  = cur.standard_enable;
               next_cur.resp_valid = 1'b1;
            end
            CMD_ESR_READ: begin
               // contents go out before the clear above takes effect
               next_cur.resp_data  = cur.standard_event_flags;
               next_cur.resp_valid = 1'b1;
            end
            CMD_CLS: begin
               next_cur.clear_events = 1'b1;
               next_cur.flush_queue  = CMD_AFTER_TERM;
            end
            CMD_OP_COMPLETE: begin
               // arming handled by the tracker instance
               next_cur.resp_valid = 1'b0;
            end
            default: begin
               next_cur.resp_valid = 1'b0;
            end
         endcase
      end

      // observable copy of the status byte as a query would see it
      next_cur.status_summary_byte = stb_query_value;
   end

   // power-on leaves the power-on flag set
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         cur.service_enable        <= SRE_RESET;
         cur.standard_enable       <= ESE_RESET;
         cur.standard_event_flags  <= SEF_RESET;
         cur.summary_prev          <= 1'b0;
         cur.request_service_latch <= 1'b0;
         cur.status_summary_byte   <= 8'h00;
         cur.resp_data             <= 8'h00;
         cur.resp_valid            <= 1'b0;
         cur.clear_events          <= 1'b0;
         cur.flush_queue           <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   // outputs straight from flip-flops
   assign RESP_VALID         = cur.resp_valid;
   assign RESP_DATA          = cur.resp_data;
   assign SERVICE_REQUEST    = cur.request_service_latch;
   assign STATUS_BYTE        = cur.status_summary_byte;
   assign CLEAR_EVENTS       = cur.clear_events;
   assign FLUSH_OUTPUT_QUEUE = cur.flush_queue;

endmodule

// *** tb/host_model.sv ***
`timescale 1ns/1ps
module host_model (
   input  wire logic       clk,
   input  wire logic       resp_valid,
   input  wire logic [7:0] resp_data,
   output logic            cmd_valid,
   output logic [3:0]      cmd_code,
   output logic [7:0]      cmd_data,
   output logic            after_term
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 4'h0;
      cmd_data = 8'h00;
      after_term = 1'b0;
   end
   // one command, held across its taking edge, answer read in the cycle after
   task automatic send(input logic [3:0] c, input logic [7:0] d,
                       output logic rv, output logic [7:0] rd);
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_data = d;
      after_term = d[0];
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      cmd_code = ~c; // released code and data lines never keep the old value; after_term keeps it
      cmd_data = ~d;
      rv = resp_valid;
      rd = resp_data;
   endtask
endmodule

// *** tb/status_report_asserts.sv ***
`timescale 1ns/1ps
module status_report_asserts #(
   parameter int EVENT_WIDTH = status_report_pkg::EVENT_WIDTH_DEFAULT
) (
   input wire logic                   CLOCK,
   input wire logic                   RSTN,
   input wire logic                   CMD_VALID,
   input wire logic [3:0]             CMD_CODE,
   input wire logic [7:0]             CMD_DATA,
   input wire logic [EVENT_WIDTH-1:0] MEASURE_EVENT,
   input wire logic [EVENT_WIDTH-1:0] MEASURE_ENABLE,
   input wire logic                   ERROR_QUEUE_NOT_EMPTY,
   input wire logic                   OUTPUT_QUEUE_NOT_EMPTY,
   input wire logic                   RESP_VALID,
   input wire logic [7:0]             RESP_DATA,
   input wire logic                   SERVICE_REQUEST,
   input wire logic [7:0]             STATUS_BYTE
);
   import status_report_pkg::*;
   logic [7:0] sre;
   // shadow of the request enable, bit 6 can never be stored
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         sre <= SRE_RESET;
      end else if (CMD_VALID && CMD_CODE == CMD_SRE_WRITE) begin
         sre <= CMD_DATA & SRE_WRITABLE;
      end
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   a_measure_bit: assert property (
      $past(RSTN) |-> STATUS_BYTE[0] == |($past(MEASURE_EVENT) & $past(MEASURE_ENABLE)))
      else $error("measure summary wrong");
   a_queue_flags: assert property (
      $past(RSTN) |-> STATUS_BYTE[2] == $past(ERROR_QUEUE_NOT_EMPTY)
                   && STATUS_BYTE[4] == $past(OUTPUT_QUEUE_NOT_EMPTY))
      else $error("queue flag wrong");
   a_unused_zero: assert property (
      STATUS_BYTE[3] == 1'b0 && STATUS_BYTE[7] == 1'b0)
      else $error("unused status bit set");
   a_master_mask: assert property (
      STATUS_BYTE[6] == |(STATUS_BYTE & $past(sre)))
      else $error("master summary wrong");
   a_request_rise: assert property (
      $rose(SERVICE_REQUEST) |-> STATUS_BYTE[6] && !$past(STATUS_BYTE[6]))
      else $error("request without summary rise");
   a_request_drop: assert property (
      SERVICE_REQUEST |-> STATUS_BYTE[6])
      else $error("request held without summary");
   a_poll_clear: assert property (
      CMD_VALID && CMD_CODE == CMD_SERIAL_POLL |=> RESP_VALID
      && RESP_DATA[6] == $past(SERVICE_REQUEST) && (!SERVICE_REQUEST || $rose(STATUS_BYTE[6])))
      else $error("serial poll wrong");
   a_query_keep: assert property (
      CMD_VALID && CMD_CODE == CMD_STB_QUERY |=> RESP_VALID && RESP_DATA == STATUS_BYTE)
      else $error("status query wrong");
   a_event_zero: assert property (
      CMD_VALID && CMD_CODE == CMD_ESR_READ |=> RESP_VALID && RESP_DATA[6] == 1'b0
      && RESP_DATA[1] == 1'b0)
      else $error("unused event bit set");
endmodule
bind status_report_service_request status_report_asserts #(.EVENT_WIDTH(EVENT_WIDTH)) chk (
   .CLOCK, .RSTN, .CMD_VALID, .CMD_CODE, .CMD_DATA, .MEASURE_EVENT, .MEASURE_ENABLE,
   .ERROR_QUEUE_NOT_EMPTY, .OUTPUT_QUEUE_NOT_EMPTY, .RESP_VALID, .RESP_DATA,
   .SERVICE_REQUEST, .STATUS_BYTE);

// *** tb/tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, a) n_tests++; if ((a) !== (e)) begin bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end
module tb;
   import status_report_pkg::*;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [15:0] me, men, se, sen;
   logic        eq, oq, rv, cv, at, resp_valid, srq, clr_ev, flush;
   logic [3:0]  errs, ops, cc;
   logic [7:0]  sre, rd, cd, resp_data, stb;
   int          bad_count = 0;
   int          n_tests = 0;
   always #12.5 clk = ~clk;
   status_report_service_request DUT (.CLOCK(clk), .RSTN(rstn), .CMD_VALID(cv),
      .CMD_CODE(cc), .CMD_DATA(cd), .CMD_AFTER_TERM(at), .SYNTAX_ERROR(errs[3]),
      .EXECUTION_ERROR(errs[2]), .INTERNAL_ERROR(errs[1]), .QUERY_ERROR(errs[0]),
      .OPS_PENDING(ops), .SOURCE_EVENT(se), .SOURCE_ENABLE(sen), .MEASURE_EVENT(me),
      .MEASURE_ENABLE(men), .ERROR_QUEUE_NOT_EMPTY(eq), .OUTPUT_QUEUE_NOT_EMPTY(oq),
      .RESP_VALID(resp_valid), .RESP_DATA(resp_data), .SERVICE_REQUEST(srq),
      .STATUS_BYTE(stb), .CLEAR_EVENTS(clr_ev), .FLUSH_OUTPUT_QUEUE(flush));
   host_model host (.clk(clk), .resp_valid(resp_valid), .resp_data(resp_data),
      .cmd_valid(cv), .cmd_code(cc), .cmd_data(cd), .after_term(at));
   // expected status byte from the current inputs
   function automatic logic [7:0] exp_stb(input logic [7:0] en, input logic standard_event_summary);
      logic [7:0] b;
      b = {2'b00, standard_event_summary, oq, 1'b0, eq, |(se & sen), |(me & men)};
      b[6] = |(b & en);
      return b;
   endfunction
   task automatic cmd(input logic [3:0] c, input logic [7:0] d);
      host.send(c, d, rv, rd);
   endtask
   task automatic pulse(input int i);
      errs[i] = 1'b1;
      @(posedge clk);
      #1;
      errs = '0;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // generous budget: the sequence needs well under a thousand cycles
   initial begin
      #100000;
      bad_count++;
      final_report();
   end
   initial begin
      {me, men, se, sen, eq, oq, errs, ops} = '0;
      void'($urandom(20991));
      repeat (3) @(posedge clk);
      #1 rstn = 1'b1;
      cmd(CMD_ESR_READ, 8'h00);
      `CHK("esr power", 8'h80, rd)
      cmd(CMD_ESR_READ, 8'h00);
      `CHK("esr cleared", 8'h00, rd)
      // random summaries against random masks, both mask extremes first
      for (int i = 0; i < 24; i++) begin
         {me, men, se, sen} = {$urandom, $urandom};
         {eq, oq, sre} = 10'($urandom);
         if (i < 2) sre = i ? 8'h00 : 8'hff;
         cmd(CMD_SRE_WRITE, sre);
         cmd(CMD_SRE_READ, 8'h00);
         `CHK("sre", sre & SRE_WRITABLE, rd)
         cmd(CMD_STB_QUERY, 8'h00);
         `CHK("answer", 1'b1, rv)
         `CHK("stb", exp_stb(sre, 1'b0), rd)
      end
      {me, se, eq, oq} = '0;
      cmd(CMD_ESE_WRITE, 8'h04);
      cmd(CMD_ESE_READ, 8'h00);
      `CHK("ese", 8'h04, rd)
      cmd(CMD_SRE_WRITE, 8'h20);
      pulse(3);
      cmd(CMD_STB_QUERY, 8'h00);
      `CHK("esb masked", 8'h00, rd)
      for (int i = 2; i >= 0; i--) pulse(i);
      cmd(CMD_STB_QUERY, 8'h00);
      `CHK("esb", 8'h60, rd)
      cmd(CMD_ESR_READ, 8'h00);
      `CHK("esr errors", 8'h3c, rd)
      cmd(CMD_SRE_WRITE, 8'h04);
      eq = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK("request", 1'b1, srq)
      cmd(CMD_SERIAL_POLL, 8'h00);
      `CHK("poll bit", 1'b1, rd[6])
      `CHK("poll clears", 1'b0, srq)
      cmd(CMD_SERIAL_POLL, 8'h00);
      `CHK("poll again", 1'b0, rd[6])
      cmd(CMD_STB_QUERY, 8'h00);
      `CHK("master kept", 1'b1, rd[6])
      pulse(3);
      oq = 1'b1;
      cmd(CMD_CLS, 8'h00);
      `CHK("clear events", 1'b1, clr_ev)
      `CHK("no flush", 1'b0, flush)
      cmd(CMD_ESR_READ, 8'h00);
      `CHK("esr after clear", 8'h00, rd)
      cmd(CMD_CLS, 8'h01);
      `CHK("flush", 1'b1, flush)
      ops = 4'h3;
      cmd(CMD_OP_COMPLETE, 8'h00);
      ops = 4'h0;
      repeat (3) @(posedge clk);
      cmd(CMD_ESR_READ, 8'h00);
      `CHK("esr complete", 8'h01, rd)
      final_report();
   end
endmodule
